// ==== dis_input_select.sv ====
// digital input source select with comm contacts, alarm options and apb regs
//
// Summary of operation
// R1 - alarm reset held: drive switching off when option x is 0, on if 1
// R2 - on warning, alarm output stays off if option y 0, asserts if 1
// R3 - ninth input function code settable, resets to 0018h, accepts up to 003Fh
// R4 - contact bits 0..8 map onto logical inputs one through nine in order
// R5 - each contact bit: 0 means off, 1 means on
// R6 - source bit 1 takes contact bit, source bit 0 takes hardware terminal
// R7 - reading contact register returns stored contact bits, set means on
// R8 - contact write updates contacts only; following depends on source bit
// R9 - input on communication source ignores its hardware terminal completely
// R10 - inputs one to eight use own function codes, input nine the ninth code
// R11 - selected input vector is registered every clock edge
`timescale 1ns/10ps

module dis_input_select
    import dis_pkg::*;
#(
    parameter int NUM_IN = DIS_NUM_IN
) (
    input  wire logic                         I_CORE_CLK,
    input  wire logic                         I_RESET,
    // apb slave
    input  wire logic                         I_PSEL,
    input  wire logic                         I_PENABLE,
    input  wire logic                         I_PWRITE,
    input  wire logic [7:0]                   I_PADDR,
    input  wire logic [31:0]                  I_PWDATA,
    output logic      [31:0]                  O_PRDATA,
    output logic                              O_PREADY,
    output logic                              O_PSLVERR,
    // hardware terminals and device events (asynchronous)
    input  wire logic [NUM_IN-1:0]            I_HW_TERMINAL,
    input  wire logic                         I_ALARM_RESET,
    input  wire logic                         I_WARNING,
    input  wire logic                         I_ALARM,
    // outputs to the drive core
    output logic      [NUM_IN-1:0]            O_LOGICAL_INPUTS,
    output logic      [NUM_IN*DIS_FUNC_W-1:0] O_INPUT_FUNCTIONS,
    output logic                              O_PWM_ENABLE,
    output logic                              O_ALARM_OUTPUT,
    output logic                              O_WARNING_OUTPUT,
    output logic                              O_IRQ
);

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    dis_apb_req_t req;
    assign req = '{sel: I_PSEL, enable: I_PENABLE, write: I_PWRITE,
                   addr: I_PADDR, wdata: I_PWDATA};

    // true when an address belongs to the register map
    function automatic logic dis_mapped(input logic [7:0] a);
        if (a == DIS_ADDR_OPTION || a == DIS_ADDR_NINTH) begin
            return 1'b1;
        end else if (a == DIS_ADDR_CONTACT || a == DIS_ADDR_SOURCE) begin
            return 1'b1;
        end else if (a == DIS_ADDR_FUNC_LO || a == DIS_ADDR_FUNC_HI) begin
            return 1'b1;
        end else if (a == DIS_ADDR_STATUS || a == DIS_ADDR_IRQ_STAT) begin
            return 1'b1;
        end else if (a == DIS_ADDR_IRQ_MASK) begin
            return 1'b1;
        end else begin
            return 1'b0;
        end
    endfunction : dis_mapped

    // access phase seen, answer in the following cycle (one wait state per access)
    logic access;
    logic wr_en;
    assign access = req.sel && req.enable && O_PREADY;
    assign wr_en  = access && req.write && dis_mapped(req.addr);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [15:0]             option_q;
    logic [DIS_FUNC_W-1:0]   ninth_func_q;
    logic [NUM_IN-1:0]       contact_q;
    logic [NUM_IN-1:0]       source_q;
    logic [DIS_FUNC_W-1:0]   func_q [0:7];
    logic [DIS_NUM_EV-1:0]   irq_stat_q;
    logic [DIS_NUM_EV-1:0]   irq_mask_q;

    // option bits outside x and y are reserved and stay zero
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            option_q <= DIS_OPTION_RST;
        end else if (wr_en && req.addr == DIS_ADDR_OPTION) begin
            option_q <= req.wdata[15:0] & DIS_OPTION_MASK;
        end
    end

    // ninth terminal function, six-bit code spans 00h..3Fh
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            ninth_func_q <= DIS_NINTH_RST; // R3
        end else if (wr_en && req.addr == DIS_ADDR_NINTH) begin
            ninth_func_q <= req.wdata[DIS_FUNC_W-1:0]; // R3
        end
    end

    // contact write touches only the contact states
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            contact_q <= DIS_CONTACT_RST;
        end else if (wr_en && req.addr == DIS_ADDR_CONTACT) begin
            contact_q <= req.wdata[NUM_IN-1:0]; // R5 R8
        end
    end

    // source select, one bit per logical input
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            source_q <= DIS_SOURCE_RST;
        end else if (wr_en && req.addr == DIS_ADDR_SOURCE) begin
            source_q <= req.wdata[NUM_IN-1:0];
        end
    end

    // function codes of inputs one to eight, four per word
    genvar gf;
    generate
        for (gf = 0; gf < 8; gf++) begin : g_func
            localparam logic [7:0] FADDR = (gf < 4) ? DIS_ADDR_FUNC_LO
                                                    : DIS_ADDR_FUNC_HI;
            localparam int LSB = (gf % 4) * DIS_FUNC_STRIDE;
            always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
                if (I_RESET) begin
                    func_q[gf] <= DIS_FUNC_RST;
                end else if (wr_en && req.addr == FADDR) begin
                    func_q[gf] <= req.wdata[LSB +: DIS_FUNC_W];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // terminal synchronisers, two flops before any use
    // ------------------------------------------------------------------
    logic [NUM_IN+2:0] sync1_q;
    logic [NUM_IN+2:0] sync2_q;

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {I_ALARM, I_WARNING, I_ALARM_RESET, I_HW_TERMINAL};
            sync2_q <= sync1_q;
        end
    end

    logic [NUM_IN-1:0] hw_s;
    logic              alarm_reset_s;
    logic              warning_s;
    logic              alarm_s;
    assign hw_s          = sync2_q[NUM_IN-1:0];
    assign alarm_reset_s = sync2_q[NUM_IN];
    assign warning_s     = sync2_q[NUM_IN+1];
    assign alarm_s       = sync2_q[NUM_IN+2];

    // ------------------------------------------------------------------
    // input selection
    // ------------------------------------------------------------------
    // mux instead of or-ing: a comm-sourced input never sees its terminal
    logic [NUM_IN-1:0] sel_d;
    assign sel_d = (source_q & contact_q) | (~source_q & hw_s); // R4 R6 R9

    logic [NUM_IN-1:0] logical_q;
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            logical_q <= '0;
        end else begin
            logical_q <= sel_d; // R11
        end
    end
    assign O_LOGICAL_INPUTS = logical_q;

    // function code bus, registered; input nine uses the ninth code
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_INPUT_FUNCTIONS <= '0;
        end else begin
            for (int i = 0; i < 8; i++) begin
                O_INPUT_FUNCTIONS[i*DIS_FUNC_W +: DIS_FUNC_W] <= func_q[i]; // R10
            end
            O_INPUT_FUNCTIONS[8*DIS_FUNC_W +: DIS_FUNC_W] <= ninth_func_q; // R10
        end
    end

    // ------------------------------------------------------------------
    // alarm reset and warning options
    // ------------------------------------------------------------------
    logic warn_alarm;
    assign warn_alarm = warning_s && option_q[DIS_OPT_Y_BIT];

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_PWM_ENABLE     <= 1'b0;
            O_ALARM_OUTPUT   <= 1'b0;
            O_WARNING_OUTPUT <= 1'b0;
        end else begin
            // outside alarm reset the drive core owns switching, so enabled
            O_PWM_ENABLE     <= !alarm_reset_s || option_q[DIS_OPT_X_BIT]; // R1
            O_ALARM_OUTPUT   <= alarm_s || warn_alarm; // R2
            O_WARNING_OUTPUT <= warning_s;
        end
    end

    // ------------------------------------------------------------------
    // interrupts: sticky events, set wins over write-one-clear
    // ------------------------------------------------------------------
    logic             warn_prev_q;
    logic [DIS_NUM_EV-1:0] ev;
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            warn_prev_q <= 1'b0;
        end else begin
            warn_prev_q <= warning_s;
        end
    end

    always_comb begin
        ev                 = '0;
        ev[DIS_EV_ALARM]   = alarm_s || warn_alarm;
        ev[DIS_EV_WARNING] = warning_s && !warn_prev_q;
        ev[DIS_EV_CHANGE]  = sel_d != logical_q;
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            irq_stat_q <= '0;
        end else begin
            if (wr_en && req.addr == DIS_ADDR_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~req.wdata[DIS_NUM_EV-1:0]) | ev;
            end else begin
                irq_stat_q <= irq_stat_q | ev;
            end
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            irq_mask_q <= '0;
        end else if (wr_en && req.addr == DIS_ADDR_IRQ_MASK) begin
            irq_mask_q <= req.wdata[DIS_NUM_EV-1:0];
        end
    end

    // irq lags the status bit by one cycle, keeps the output a flop
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_IRQ <= 1'b0;
        end else begin
            O_IRQ <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ------------------------------------------------------------------
    // apb answer: pready one cycle into the access phase
    // ------------------------------------------------------------------
    logic [31:0] rd_d;
    always_comb begin
        rd_d = DIS_ZERO_WORD;
        if (req.addr == DIS_ADDR_OPTION) begin
            rd_d[15:0] = option_q;
        end else if (req.addr == DIS_ADDR_NINTH) begin
            rd_d[DIS_FUNC_W-1:0] = ninth_func_q;
        end else if (req.addr == DIS_ADDR_CONTACT) begin
            rd_d[NUM_IN-1:0] = contact_q; // R7
        end else if (req.addr == DIS_ADDR_SOURCE) begin
            rd_d[NUM_IN-1:0] = source_q;
        end else if (req.addr == DIS_ADDR_FUNC_LO) begin
            for (int i = 0; i < 4; i++) begin
                rd_d[i*DIS_FUNC_STRIDE +: DIS_FUNC_W] = func_q[i];
            end
        end else if (req.addr == DIS_ADDR_FUNC_HI) begin
            for (int i = 0; i < 4; i++) begin
                rd_d[i*DIS_FUNC_STRIDE +: DIS_FUNC_W] = func_q[i+4];
            end
        end else if (req.addr == DIS_ADDR_STATUS) begin
            rd_d[NUM_IN-1:0] = logical_q;
        end else if (req.addr == DIS_ADDR_IRQ_STAT) begin
            rd_d[DIS_NUM_EV-1:0] = irq_stat_q;
        end else if (req.addr == DIS_ADDR_IRQ_MASK) begin
            rd_d[DIS_NUM_EV-1:0] = irq_mask_q;
        end
    end

    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            O_PREADY  <= 1'b0;
            O_PRDATA  <= DIS_ZERO_WORD;
            O_PSLVERR <= 1'b0;
        end else if (req.sel && req.enable && !O_PREADY) begin
            O_PREADY  <= 1'b1;
            O_PRDATA  <= req.write ? DIS_ZERO_WORD : rd_d;
            O_PSLVERR <= !dis_mapped(req.addr);
        end else begin
            O_PREADY  <= 1'b0;
            O_PRDATA  <= DIS_ZERO_WORD;
            O_PSLVERR <= 1'b0;
        end
    end

endmodule : dis_input_select

// ==== dis_input_select_props.sv ====
// checker: port-level properties of the input source select block
`timescale 1ns/10ps
module dis_input_select_props
    import dis_pkg::*;
#(
    parameter int NUM_IN = DIS_NUM_IN
) (
    input wire logic I_CORE_CLK, I_RESET, I_PSEL, I_PENABLE, I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA, O_PRDATA,
    input wire logic O_PREADY, O_PSLVERR, I_ALARM_RESET, I_WARNING, I_ALARM,
    input wire logic [NUM_IN-1:0] I_HW_TERMINAL, O_LOGICAL_INPUTS,
    input wire logic [NUM_IN*DIS_FUNC_W-1:0] O_INPUT_FUNCTIONS,
    input wire logic O_PWM_ENABLE, O_ALARM_OUTPUT, O_WARNING_OUTPUT, O_IRQ
);
    logic [2:0]        up_q;
    logic [NUM_IN-1:0] cnt_q, src_q;
    logic [5:0]        ninth_q;
    logic [13:0]       flo_q;
    logic              opt_x_q, opt_y_q;
    wire wr = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
    wire rd = I_PSEL & I_PENABLE & O_PREADY & !I_PWRITE;
    wire up = (up_q == 3'd7);  // sync pipes hold reset values at first
    // shadow of the registers, so outputs can be tied to what was written
    always_ff @(posedge I_CORE_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            up_q <= '0;
            cnt_q <= '0;
            src_q <= '0;
            ninth_q <= 6'h18;
            flo_q <= '0;
            opt_x_q <= 1'b0;
            opt_y_q <= 1'b0;
        end else begin
            if (!up) up_q <= up_q + 3'd1;
            if (wr && I_PADDR == DIS_ADDR_CONTACT) cnt_q <= I_PWDATA[8:0];
            if (wr && I_PADDR == DIS_ADDR_SOURCE) src_q <= I_PWDATA[8:0];
            if (wr && I_PADDR == DIS_ADDR_NINTH) ninth_q <= I_PWDATA[5:0];
            if (wr && I_PADDR == DIS_ADDR_FUNC_LO) flo_q <= I_PWDATA[13:0];
            if (wr && I_PADDR == DIS_ADDR_OPTION) opt_x_q <= I_PWDATA[0];
            if (wr && I_PADDR == DIS_ADDR_OPTION) opt_y_q <= I_PWDATA[4];
        end
    end
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RESET);
    a_pwm_reset_opt: assert property (up |-> O_PWM_ENABLE ==
        (!$past(I_ALARM_RESET, 3) || $past(opt_x_q)))
        else $error("pwm enable wrong for alarm reset option");
    a_alarm_on_warn: assert property (up |-> O_ALARM_OUTPUT ==
        ($past(I_ALARM, 3) | ($past(I_WARNING, 3) & $past(opt_y_q))))
        else $error("alarm output wrong for warning option");
    a_input_source_mux: assert property (up |->
        O_LOGICAL_INPUTS == (($past(src_q) & $past(cnt_q))
        | (~$past(src_q) & $past(I_HW_TERMINAL, 3))))
        else $error("logical inputs not from selected source");
    a_ninth_code: assert property (up |->
        O_INPUT_FUNCTIONS[NUM_IN*DIS_FUNC_W-1 -: 6] == $past(ninth_q))
        else $error("ninth function code wrong");
    a_first_funcs: assert property (up |->
        O_INPUT_FUNCTIONS[11:0] == $past({flo_q[13:8], flo_q[5:0]}))
        else $error("input one or two function code wrong");
    a_read_contact: assert property (rd && I_PADDR == DIS_ADDR_CONTACT
        |-> O_PRDATA == {23'h00_0000, cnt_q})
        else $error("contact read data wrong");
    a_one_wait: assert property ($rose(I_PENABLE) && I_PSEL |->
        !O_PREADY ##1 O_PREADY) else $error("ready not after one wait");
    a_unmapped_err: assert property (O_PREADY && I_PADDR > 8'h20 |->
        O_PSLVERR && O_PRDATA == 32'h0000_0000)
        else $error("unmapped access not refused");
    c_contact_wr: cover property (wr && I_PADDR == DIS_ADDR_CONTACT);
    c_pwm_held: cover property (up && I_ALARM_RESET && !O_PWM_ENABLE);
    c_irq: cover property (O_IRQ);
endmodule : dis_input_select_props

bind dis_input_select dis_input_select_props #(.NUM_IN(NUM_IN)) u_props (
    .I_CORE_CLK(I_CORE_CLK), .I_RESET(I_RESET), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
    .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
    .O_PSLVERR(O_PSLVERR), .I_ALARM_RESET(I_ALARM_RESET),
    .I_WARNING(I_WARNING), .I_ALARM(I_ALARM), .I_HW_TERMINAL(I_HW_TERMINAL),
    .O_LOGICAL_INPUTS(O_LOGICAL_INPUTS), .O_PWM_ENABLE(O_PWM_ENABLE),
    .O_INPUT_FUNCTIONS(O_INPUT_FUNCTIONS), .O_ALARM_OUTPUT(O_ALARM_OUTPUT),
    .O_WARNING_OUTPUT(O_WARNING_OUTPUT), .O_IRQ(O_IRQ));

// ==== dis_pkg.sv ====
// package: register map, field layouts and reset values for input source select
package dis_pkg;

    // ------------------------------------------------------------------
    // register byte addresses (apb, one aligned word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] DIS_ADDR_OPTION = 8'h00; // alarm_reset_warning_option
    localparam logic [7:0] DIS_ADDR_NINTH  = 8'h04; // ninth_input_function_select
    localparam logic [7:0] DIS_ADDR_CONTACT = 8'h08; // comm_input_contact_state
    localparam logic [7:0] DIS_ADDR_SOURCE = 8'h0C; // input_source_select
    localparam logic [7:0] DIS_ADDR_FUNC_LO = 8'h10; // functions of inputs 1..4
    localparam logic [7:0] DIS_ADDR_FUNC_HI = 8'h14; // functions of inputs 5..8
    localparam logic [7:0] DIS_ADDR_STATUS = 8'h18; // live logical inputs, ro
    localparam logic [7:0] DIS_ADDR_IRQ_STAT = 8'h1C; // sticky events, w1c
    localparam logic [7:0] DIS_ADDR_IRQ_MASK = 8'h20; // interrupt enables

    // ------------------------------------------------------------------
    // widths, fields and reset values
    // ------------------------------------------------------------------
    localparam int          DIS_NUM_IN      = 9;
    localparam int          DIS_FUNC_W      = 6;
    localparam int          DIS_REG_W       = 16;
    localparam int          DIS_OPT_X_BIT   = 0;
    localparam int          DIS_OPT_Y_BIT   = 4;
    localparam logic [15:0] DIS_OPTION_MASK = 16'h0011;
    localparam logic [15:0] DIS_OPTION_RST  = 16'h0000;
    localparam logic [5:0]  DIS_NINTH_RST   = 6'h18;
    localparam logic [5:0]  DIS_FUNC_RST    = 6'h00;
    localparam logic [8:0]  DIS_CONTACT_RST = 9'h000;
    localparam logic [8:0]  DIS_SOURCE_RST  = 9'h000;
    localparam int          DIS_FUNC_STRIDE = 8;  // one function code a byte
    localparam logic [31:0] DIS_ZERO_WORD   = 32'h0000_0000;

    // interrupt event bit positions
    localparam int DIS_EV_ALARM   = 0;  // alarm output asserted
    localparam int DIS_EV_WARNING = 1;  // warning input rose
    localparam int DIS_EV_CHANGE  = 2;  // any logical input changed
    localparam int DIS_NUM_EV     = 3;

    // apb request carried as one bundle
    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } dis_apb_req_t;

endpackage : dis_pkg

// ==== dis_term_model.sv ====
// partner model: field terminals and device events seen by the block
`timescale 1ns/10ps
module dis_term_model (
    input  wire logic        i_clk,
    input  wire logic [11:0] i_cmd,  // {alarm, warning, alarm reset, terms}
    output logic      [8:0]  o_term        = '0,
    output logic             o_alarm_reset = 1'b0,
    output logic             o_warning     = 1'b0,
    output logic             o_alarm       = 1'b0
);
    // levels step only just after an edge, like a real contact bank
    always @(posedge i_clk) begin
        {o_alarm, o_warning, o_alarm_reset, o_term} <= i_cmd;
    end
endmodule : dis_term_model

// ==== tb_digital_input_source_select.sv ====
// testbench: apb host plus terminal model around the input source select
`timescale 1ns/10ps
module tb_digital_input_source_select;
    import dis_pkg::*;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic        pready, pslverr, pwm, alarm_output, warning_output, irq, ar, wn, al;
    logic [11:0] cmd = '0;
    logic [8:0]  term, li;
    logic [53:0] fn;
    logic [32:0] rq[$];  // expected {slverr, data} of each read
    int          fail_count = 0, n_compared = 0;
    always #12.5 clk = ~clk;
    dis_term_model u_term (.i_clk(clk), .i_cmd(cmd), .o_term(term),
        .o_alarm_reset(ar), .o_warning(wn), .o_alarm(al));
    dis_input_select u_dut (.I_CORE_CLK(clk), .I_RESET(rst), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
        .I_HW_TERMINAL(term), .I_ALARM_RESET(ar), .I_WARNING(wn),
        .I_ALARM(al), .O_LOGICAL_INPUTS(li), .O_INPUT_FUNCTIONS(fn),
        .O_PWM_ENABLE(pwm), .O_ALARM_OUTPUT(alarm_output), .O_WARNING_OUTPUT(warning_output),
        .O_IRQ(irq));
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [53:0] g, input logic [53:0] e,
                       input string m);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    // one apb transfer; waits for ready with a bound, never a fixed count
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            stop_test();
        end
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    // read monitor: oldest note is matched at the ready edge
    always @(posedge clk) begin
        if (psel && pen && !pwr && pready === 1'b1) begin
            chk({pslverr, prdata}, rq.pop_front(), "read data");
        end
    end
    // a hang ends in the same closing report
    initial begin
        #2000000;
        fail_count++;
        stop_test();
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [8:0]  s, c, t;
        logic [31:0] nine[3] = '{32'h0000_003F, 32'h0, 32'h0000_0155};
        logic [8:0]  ts[3] = '{9'h1C0, 9'h000, 9'h1FF};
        logic [8:0]  tc[3] = '{9'h038, 9'h1FF, 9'h000};
        logic [8:0]  tt[3] = '{9'h10F, 9'h0A5, 9'h1FF};
        void'($urandom(56692));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(DIS_ADDR_OPTION, 33'h0);
        rd(DIS_ADDR_NINTH, 33'h18);
        rd(DIS_ADDR_CONTACT, 33'h0);
        chk(fn[53:48], 54'h18, "ninth reset code");
        // ninth code: top of range, zero, and a value with high junk bits
        foreach (nine[i]) begin
            apb(1'b1, DIS_ADDR_NINTH, nine[i]);
            rd(DIS_ADDR_NINTH, {27'h0, nine[i][5:0]});
            wt(2);
            chk(fn[53:48], nine[i][5:0], "ninth function");
        end
        apb(1'b1, DIS_ADDR_FUNC_LO, 32'h0403_0201);
        apb(1'b1, DIS_ADDR_FUNC_HI, 32'h0807_0605);
        wt(2);
        chk(fn[47:0], {6'h8, 6'h7, 6'h6, 6'h5, 6'h4, 6'h3, 6'h2, 6'h1},
            "first eight functions");
        // source mix: fixed corner cases first, then random ones
        for (int i = 0; i < 10; i++) begin
            s = (i < 3) ? ts[i] : 9'($urandom);
            c = (i < 3) ? tc[i] : 9'($urandom);
            t = (i < 3) ? tt[i] : 9'($urandom);
            apb(1'b1, DIS_ADDR_SOURCE, {23'h0, s});
            apb(1'b1, DIS_ADDR_CONTACT, {23'h0, c});
            cmd <= {3'b000, t};
            wt(5);
            chk(li, (s & c) | (~s & t), "logical inputs");
            rd(DIS_ADDR_CONTACT, {24'h0, c});
        end
        // every alarm reset and warning option with both conditions held
        cmd <= 12'h600;
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, DIS_ADDR_OPTION, {27'h0, k[1], 3'h0, k[0]});
            wt(5);
            chk(pwm, k[0], "pwm under alarm reset");
            chk(alarm_output, k[1], "alarm on warning");
            chk(warning_output, 1'b1, "warning output");
        end
        apb(1'b1, DIS_ADDR_OPTION, 32'h0000_FFFF);
        rd(DIS_ADDR_OPTION, 33'h11);
        apb(1'b1, DIS_ADDR_OPTION, 32'h0);
        cmd <= 12'h800;
        wt(5);
        chk(pwm, 1'b1, "pwm without alarm reset");
        chk(alarm_output, 1'b1, "alarm passes through");
        cmd <= 12'h000;
        wt(5);
        // interrupt: sticky, masked, unmasked, then cleared by a one
        apb(1'b1, DIS_ADDR_IRQ_STAT, 32'h0000_0007);
        rd(DIS_ADDR_IRQ_STAT, 33'h0);
        cmd <= 12'h400;
        wt(5);
        rd(DIS_ADDR_IRQ_STAT, 33'h2);
        chk(irq, 1'b0, "masked interrupt");
        apb(1'b1, DIS_ADDR_IRQ_MASK, 32'h0000_0002);
        wt(3);
        chk(irq, 1'b1, "interrupt raised");
        apb(1'b1, DIS_ADDR_IRQ_STAT, 32'h0000_0002);
        wt(3);
        chk(irq, 1'b0, "interrupt cleared");
        rd(8'h40, 33'h1_0000_0000);
        wt(3);
        stop_test();
    end
endmodule : tb_digital_input_source_select
